// >>> rtl/tsx_exec.sv
// What this block does
// - Decode the test-and-skip-if-zero word 0110 011a ffff ffff and leave all flags alone.
// - If the tested register is zero, drop the fetched next instruction and run an idle slot.
// - Test-and-skip takes one instruction cycle without skip and two with a one-word skip.
// - Skipping a two-word instruction flushes both words, three instruction cycles total.
// - With the bank bit clear and the operand not indexed (see below), the register lies in the fixed access bank.
// - With the bank bit set the address is the bank select pointer joined to the operand.
// - Extended set on, bank bit clear and operand up to 95: operand is an offset from the base.
// - The XOR-literal instruction XORs the accumulator with its literal into the accumulator.
// - Decode XOR-literal from upper byte 0000 1010, literal in the low byte.
// - XOR-literal changes only the negative and zero flags.
`timescale 1ns/100ps
`default_nettype none
module tsx_exec
    import tsx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Instruction stream from fetch
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    input wire logic next_two_word,
    output logic busy,
    // Data memory read port
    output logic [11:0] dmem_addr,
    output logic dmem_rd,
    input wire logic [7:0] dmem_data,
    // Pipeline effects and core state
    output logic flush,
    output logic idle_slot,
    output logic [7:0] acc,
    output logic [7:0] status
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        tsx_state_e state;
        logic [1:0] q;
        logic is_tst;
        logic [7:0] opnd;
        logic [11:0] dmem_addr;
        logic dmem_rd;
        logic data_zero;
        logic two_word;
        logic [3:0] skip_cnt;
        logic [7:0] acc;
        logic [7:0] status;
        logic ext_en;
        logic [3:0] bank;
        logic [11:0] base;
        logic flush;
        logic idle_slot;
        logic busy;
        logic [1:0] last_cycles;
        logic last_skip;
        logic waitrequest;
        logic [31:0] readdata;
    } tsx_exec_s;

    localparam tsx_exec_s ST_RESET = '{
        state: ST_IDLE,
        acc: ACC_RESET,
        status: STATUS_RESET,
        ext_en: EXT_EN_RESET,
        bank: BANK_RESET,
        base: BASE_RESET,
        waitrequest: 1'b1,
        default: '0
    };

    tsx_exec_s st;
    tsx_exec_s next_st;
    logic dec_tst;
    logic dec_xor;
    logic take;
    logic fin;
    logic tst_fin;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // Operand helpers
    // ------------------------------------------------------------
    tsx_op_if op ();

    assign op.f = instr_word[7:0];
    assign op.a = instr_word[BANK_BIT];
    assign op.ext_en = st.ext_en;
    assign op.bank = st.bank;
    assign op.base = st.base;
    assign op.acc = st.acc;
    assign op.k = st.opnd;

    tsx_addr_resolve u_addr (
        .op(op.addr_unit)
    );

    tsx_xor_alu u_alu (
        .op(op.alu_unit)
    );

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign dec_tst = (instr_word[15:9] == OPC_TST);
    assign dec_xor = (instr_word[15:8] == OPC_XOR);
    // Other opcodes belong to other units and are simply not taken
    assign take = (st.state == ST_IDLE) && instr_valid && (dec_tst || dec_xor);
    assign fin = (st.state == ST_EXEC) && (st.q == Q_LAST);
    assign tst_fin = fin && st.is_tst;

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            REG_CTRL: rd_mux[CTRL_EXT_BIT] = st.ext_en;
            REG_BANK: rd_mux[3:0] = st.bank;
            REG_BASE: rd_mux[11:0] = st.base;
            REG_ACC: rd_mux[7:0] = st.acc;
            REG_STATUS: rd_mux[7:0] = st.status;
            REG_INFO: begin
                rd_mux[INFO_BUSY_BIT] = st.busy;
                rd_mux[INFO_CYC_LSB +: 2] = st.last_cycles;
                rd_mux[INFO_SKIP_BIT] = st.last_skip;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.flush = 1'b0;
        next_st.waitrequest = 1'b1;

        // One wait cycle per access keeps readdata a plain flop
        if ((avs_read || avs_write) && st.waitrequest) begin
            next_st.waitrequest = 1'b0;
            if (avs_read) begin
                next_st.readdata = rd_mux;
            end
        end
        if (avs_write && !st.waitrequest) begin
            case (avs_address)
                REG_CTRL: if (avs_byteenable[0]) begin
                    next_st.ext_en = avs_writedata[CTRL_EXT_BIT];
                end
                REG_BANK: if (avs_byteenable[0]) begin
                    next_st.bank = avs_writedata[3:0];
                end
                REG_BASE: begin
                    if (avs_byteenable[0]) begin
                        next_st.base[7:0] = avs_writedata[7:0];
                    end
                    if (avs_byteenable[1]) begin
                        next_st.base[11:8] = avs_writedata[11:8];
                    end
                end
                // Core state is frozen while an instruction is in flight
                REG_ACC: if (avs_byteenable[0] && !st.busy) begin
                    next_st.acc = avs_writedata[7:0];
                end
                REG_STATUS: if (avs_byteenable[0] && !st.busy) begin
                    next_st.status = avs_writedata[7:0];
                end
                default: next_st.readdata = st.readdata;
            endcase
        end

        case (st.state)
            ST_IDLE: begin
                if (take) begin
                    next_st.state = ST_EXEC;
                    next_st.q = Q_FIRST;
                    next_st.busy = 1'b1;
                    next_st.is_tst = dec_tst;
                    next_st.opnd = instr_word[7:0];
                    next_st.dmem_addr = op.addr;
                    next_st.dmem_rd = dec_tst;
                    next_st.two_word = 1'b0;
                end
            end
            ST_EXEC: begin
                next_st.q = st.q + 2'h1;
                if (st.q == Q_READ) begin
                    next_st.dmem_rd = 1'b0;
                    next_st.data_zero = (dmem_data == 8'h00);
                end
                if (st.q == Q_PROC) begin
                    next_st.two_word = next_two_word;
                end
                if (st.q == Q_LAST) begin
                    if (st.is_tst && st.data_zero) begin
                        next_st.state = ST_SKIP;
                        next_st.flush = 1'b1;
                        next_st.idle_slot = 1'b1;
                        next_st.last_skip = 1'b1;
                        if (st.two_word) begin
                            next_st.skip_cnt = SKIP_CLKS_TWO;
                            next_st.last_cycles = CYC_SKIP_TWO;
                        end else begin
                            next_st.skip_cnt = SKIP_CLKS_ONE;
                            next_st.last_cycles = CYC_SKIP_ONE;
                        end
                    end else begin
                        next_st.state = ST_IDLE;
                        next_st.busy = 1'b0;
                        next_st.last_skip = 1'b0;
                        next_st.last_cycles = CYC_PLAIN;
                        if (!st.is_tst) begin
                            next_st.acc = op.result;
                            next_st.status[STAT_N_BIT] = op.neg;
                            next_st.status[STAT_Z_BIT] = op.zero;
                        end
                    end
                end
            end
            ST_SKIP: begin
                next_st.skip_cnt = st.skip_cnt - 4'h1;
                if (st.skip_cnt == 4'h1) begin
                    next_st.state = ST_IDLE;
                    next_st.idle_slot = 1'b0;
                    next_st.busy = 1'b0;
                end
            end
            default: begin
                next_st = ST_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign avs_readdata = st.readdata;
    assign avs_waitrequest = st.waitrequest;
    assign busy = st.busy;
    // No write port exists: the tested register can only be read
    assign dmem_addr = st.dmem_addr;
    assign dmem_rd = st.dmem_rd;
    assign flush = st.flush;
    assign idle_slot = st.idle_slot;
    assign acc = st.acc;
    assign status = st.status;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_tst_decode;
        (take && dec_tst) |=> (st.busy && st.is_tst && st.dmem_rd);
    endproperty
    a_tst_decode: assert property (p_tst_decode) else $error("tst not decoded");

    property p_tst_no_flags;
        tst_fin |=> (st.status == $past(st.status));
    endproperty
    a_tst_no_flags: assert property (p_tst_no_flags) else $error("tst changed flags");

    property p_skip_zero;
        (tst_fin && st.data_zero) |=> (st.flush && st.idle_slot && st.busy);
    endproperty
    a_skip_zero: assert property (p_skip_zero) else $error("zero did not skip");

    property p_no_skip;
        (tst_fin && !st.data_zero) |=> (!st.busy && !st.idle_slot && !st.flush
                                        && st.last_cycles == CYC_PLAIN);
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("nonzero took extra cycles");

    property p_skip_one;
        (tst_fin && st.data_zero && !st.two_word) |=>
            st.idle_slot [*4] ##1 (!st.busy && st.last_cycles == CYC_SKIP_ONE);
    endproperty
    a_skip_one: assert property (p_skip_one) else $error("one-word skip length wrong");

    property p_skip_two;
        (tst_fin && st.data_zero && st.two_word) |=>
            st.idle_slot [*8] ##1 (!st.busy && st.last_cycles == CYC_SKIP_TWO);
    endproperty
    a_skip_two: assert property (p_skip_two) else $error("two-word skip length wrong");

    property p_access_bank;
        (take && !instr_word[BANK_BIT] && !(st.ext_en && instr_word[7:0] <= IDX_MAX)) |=>
            (st.dmem_addr == {($past(instr_word[7:0]) < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK,
                              $past(instr_word[7:0])});
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank address");

    property p_banked;
        (take && instr_word[BANK_BIT]) |=>
            (st.dmem_addr == {$past(st.bank), $past(instr_word[7:0])});
    endproperty
    a_banked: assert property (p_banked) else $error("banked address wrong");

    property p_indexed;
        (take && !instr_word[BANK_BIT] && st.ext_en && instr_word[7:0] <= IDX_MAX) |=>
            (st.dmem_addr == $past(st.base) + {4'h0, $past(instr_word[7:0])});
    endproperty
    a_indexed: assert property (p_indexed) else $error("indexed address wrong");

    property p_xor_result;
        (fin && !st.is_tst) |=> (st.acc == ($past(st.acc) ^ $past(st.opnd)));
    endproperty
    a_xor_result: assert property (p_xor_result) else $error("xor result wrong");

    property p_xor_decode;
        (take && dec_xor) |=> (st.busy && !st.is_tst && st.opnd == $past(instr_word[7:0]))
            ##3 !st.busy;
    endproperty
    a_xor_decode: assert property (p_xor_decode) else $error("xor decode or timing");

    property p_xor_flags;
        (fin && !st.is_tst) |=> (st.status[STAT_N_BIT] == st.acc[7]
            && st.status[STAT_Z_BIT] == (st.acc == 8'h00)
            && ((st.status ^ $past(st.status)) & ~FLAG_MASK) == 8'h00);
    endproperty
    a_xor_flags: assert property (p_xor_flags) else $error("xor flags wrong");

    property p_tst_no_write;
        tst_fin |=> (st.acc == $past(st.acc));
    endproperty
    a_tst_no_write: assert property (p_tst_no_write) else $error("tst wrote acc");

    c_skip_one: cover property (tst_fin && st.data_zero && !st.two_word);
    c_skip_two: cover property (tst_fin && st.data_zero && st.two_word);
    c_no_skip: cover property (tst_fin && !st.data_zero);
    c_xor_zero: cover property ((fin && !st.is_tst) ##1 st.status[STAT_Z_BIT]);

endmodule
`default_nettype wire

// >>> rtl/tsx_pkg.sv
package tsx_pkg;

    // ------------------------------------------------------------
    // Opcodes and addressing
    // ------------------------------------------------------------
    localparam logic [6:0] OPC_TST = 7'h33;
    localparam logic [7:0] OPC_XOR = 8'h0a;
    localparam logic [7:0] IDX_MAX = 8'h5f;
    localparam logic [7:0] ACC_SPLIT = 8'h60;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    localparam int BANK_BIT = 8;

    // ------------------------------------------------------------
    // Timing in clocks, four phases per instruction cycle
    // ------------------------------------------------------------
    localparam logic [1:0] Q_FIRST = 2'h1;
    localparam logic [1:0] Q_READ = 2'h1;
    localparam logic [1:0] Q_PROC = 2'h2;
    localparam logic [1:0] Q_LAST = 2'h3;
    localparam logic [3:0] SKIP_CLKS_ONE = 4'h4;
    localparam logic [3:0] SKIP_CLKS_TWO = 4'h8;
    localparam logic [1:0] CYC_PLAIN = 2'h1;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;

    // ------------------------------------------------------------
    // Register map, byte offsets
    // ------------------------------------------------------------
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_BANK = 5'h04;
    localparam logic [4:0] REG_BASE = 5'h08;
    localparam logic [4:0] REG_ACC = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_INFO = 5'h14;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EXT_BIT = 0;
    localparam int STAT_Z_BIT = 2;
    localparam int STAT_N_BIT = 4;
    localparam logic [7:0] FLAG_MASK = (8'h01 << STAT_N_BIT) | (8'h01 << STAT_Z_BIT);
    localparam int INFO_BUSY_BIT = 0;
    localparam int INFO_CYC_LSB = 1;
    localparam int INFO_SKIP_BIT = 3;
    localparam logic EXT_EN_RESET = 1'b1;
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [11:0] BASE_RESET = 12'h000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_SKIP = 3'b100
    } tsx_state_e;

endpackage

// >>> rtl/tsx_op_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tsx_op_if;
    logic [7:0] f;
    logic a;
    logic ext_en;
    logic [3:0] bank;
    logic [11:0] base;
    logic [11:0] addr;
    logic indexed;
    logic [7:0] acc;
    logic [7:0] k;
    logic [7:0] result;
    logic neg;
    logic zero;
    modport core (output f, a, ext_en, bank, base, acc, k,
                  input addr, indexed, result, neg, zero);
    modport addr_unit (input f, a, ext_en, bank, base, output addr, indexed);
    modport alu_unit (input acc, k, output result, neg, zero);
endinterface
`default_nettype wire

// >>> rtl/tsx_addr_resolve.sv
`timescale 1ns/100ps
`default_nettype none
module tsx_addr_resolve
    import tsx_pkg::*;
(
    // Operand in, address out
    tsx_op_if.addr_unit op
);
    always_comb begin
        op.indexed = op.ext_en && !op.a && (op.f <= IDX_MAX);
        if (op.a) begin
            op.addr = {op.bank, op.f};
        end else if (op.indexed) begin
            op.addr = op.base + {4'h0, op.f};
        end else if (op.f < ACC_SPLIT) begin
            op.addr = {ACC_LO_BANK, op.f};
        end else begin
            op.addr = {ACC_HI_BANK, op.f};
        end
    end
endmodule
`default_nettype wire

// >>> rtl/tsx_xor_alu.sv
`timescale 1ns/100ps
`default_nettype none
module tsx_xor_alu
    import tsx_pkg::*;
(
    // Accumulator and literal in, result and flags out
    tsx_op_if.alu_unit op
);
    always_comb begin
        op.result = op.acc ^ op.k;
        op.neg = op.result[7];
        op.zero = (op.result == 8'h00);
    end
endmodule
`default_nettype wire

// >>> verification/test_tsx_exec.sv
`timescale 1ns/100ps
`default_nettype none
module test_tsx_exec
    import tsx_pkg::*;
;
    logic clk, rst_n;
    logic [4:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rd, seed, r;
    logic [3:0] avs_byteenable, bank_m;
    logic [15:0] instr_word;
    logic instr_valid, next_two_word, busy, dmem_rd, flush, idle_slot, ext_m, zr, two;
    logic [11:0] dmem_addr, base_m, ra, ea;
    logic [7:0] dmem_data, acc, status, acc_m, st_m, k, f;
    logic [7:0] mem [0:4095];
    logic [11:0] tc [8] = '{12'h63c, 12'hfc7, 12'ha5f, 12'h800, 12'hb60, 12'h220, 12'h1ff,
        12'h35f};
    int mismatches, n_tests, n, nf, ni, nr;

    // Memory answers within the read cycle; scrambled otherwise so stale data never matches
    assign dmem_data = dmem_rd ? mem[dmem_addr] : ~mem[dmem_addr];

    tsx_exec dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .instr_word(instr_word), .instr_valid(instr_valid), .next_two_word(next_two_word),
        .busy(busy), .dmem_addr(dmem_addr), .dmem_rd(dmem_rd), .dmem_data(dmem_data),
        .flush(flush), .idle_slot(idle_slot), .acc(acc), .status(status));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk);
        // No limit of its own: a slave that never answers is ended by the watchdog
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Offers one instruction; a literal op rides along while busy and must be refused
    task automatic run(input logic [15:0] w, input logic tw);
        n = 0;
        nf = 0;
        ni = 0;
        nr = 0;
        ra = 12'h000;
        @(posedge clk);
        instr_word <= w;
        instr_valid <= 1'b1;
        next_two_word <= tw;
        @(posedge clk);
        instr_word <= {OPC_XOR, 8'h5a};
        while (n < 20) begin
            @(posedge clk);
            n++;
            instr_word <= 16'hffff;
            nf += (flush === 1'b1);
            ni += (idle_slot === 1'b1);
            if (dmem_rd === 1'b1) begin
                nr++;
                ra = dmem_addr;
            end
            if (busy === 1'b0) break;
        end
        instr_valid <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog, main sequence
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        #2000000;
        mismatches++;
        give_verdict();
    end

    initial begin
        seed = 32'd58;
        rst_n = 1'b0;
        {avs_address, avs_read, avs_write, avs_writedata} = '0;
        avs_byteenable = 4'hf;
        {instr_word, instr_valid, next_two_word} = '0;
        for (int i = 0; i < 4096; i++) begin
            r = rnd();
            mem[i] = r[7:0] | 8'h01;
        end
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdchk(REG_CTRL, {31'h0, EXT_EN_RESET});
        rdchk(REG_BANK, {28'h0, BANK_RESET});
        rdchk(REG_BASE, {20'h0, BASE_RESET});
        rdchk(REG_ACC, {24'h0, ACC_RESET});
        rdchk(REG_STATUS, {24'h0, STATUS_RESET});
        // Index base written lane by lane: only the enabled byte may change
        bus(1'b1, REG_BASE, 32'h0000_0abc);
        avs_byteenable <= 4'h1;
        bus(1'b1, REG_BASE, 32'h0000_0f12);
        avs_byteenable <= 4'hf;
        rdchk(REG_BASE, 32'h0000_0a12);
        bus(1'b1, 5'h18, 32'hffff_ffff);
        rdchk(5'h18, 32'h0);
        r = rnd();
        acc_m = r[7:0];
        st_m = r[15:8];
        bus(1'b1, REG_ACC, {24'h0, acc_m});
        bus(1'b1, REG_STATUS, {24'h0, st_m});
        rdchk(REG_STATUS, {24'h0, st_m});
        // Literal XOR, one pass lands on a zero result
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            k = (i == 3) ? acc_m : r[7:0];
            run({OPC_XOR, k}, r[8]);
            acc_m = acc_m ^ k;
            st_m = (st_m & ~FLAG_MASK) | (acc_m[7] ? (8'h01 << STAT_N_BIT) : 8'h00)
                | ((acc_m == 8'h00) ? (8'h01 << STAT_Z_BIT) : 8'h00);
            chk(acc, acc_m);
            chk(status, st_m);
            chk(n, 4);
            chk(nf + ni + nr, 0);
            rdchk(REG_INFO, 32'h2);
        end
        // Test and skip over every addressing path
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            {ext_m, zr, two, f} = {tc[i][11], tc[i][9:0]};
            bank_m = r[3:0];
            base_m = r[15:4];
            bus(1'b1, REG_CTRL, {31'h0, ext_m});
            bus(1'b1, REG_BANK, {28'h0, bank_m});
            bus(1'b1, REG_BASE, {20'h0, base_m});
            ea = tc[i][10] ? {bank_m, f} : (ext_m && f <= IDX_MAX) ? base_m + {4'h0, f}
                : {(f < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, f};
            mem[ea] = zr ? 8'h00 : (r[23:16] | 8'h01);
            run({OPC_TST, tc[i][10], f}, two);
            chk(ra, ea);
            chk(nr, 1);
            chk(n, zr ? (two ? 12 : 8) : 4);
            chk(nf, zr);
            chk(ni, zr ? (two ? 8 : 4) : 0);
            chk(acc, acc_m);
            chk(status, st_m);
            rdchk(REG_INFO, {28'h0, zr, zr ? (two ? 2'h3 : 2'h2) : 2'h1, 1'b0});
            mem[ea] = r[31:24] | 8'h01;
        end
        // Reset in mid-instruction clears the core state at once
        @(posedge clk);
        instr_word <= {OPC_XOR, 8'hff};
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        rst_n <= 1'b0;
        @(posedge clk);
        chk({busy, flush, idle_slot, acc, status}, {3'b000, ACC_RESET, STATUS_RESET});
        rst_n <= 1'b1;
        rdchk(REG_CTRL, {31'h0, EXT_EN_RESET});
        give_verdict();
    end
endmodule
`default_nettype wire
